//--- src/lcd_read_defines.vh
// Constants for the LCD host read and initialisation block.
// Assumes a 200 MHz system clock and word-aligned AXI4-Lite registers.
`ifndef LCD_READ_DEFINES_VH
`define LCD_READ_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_ADDR_COUNTER   4'h0
`define REG_READ_STAGING   4'h4
`define REG_STATUS         4'h8
`define REG_SLAVE_ADDR     4'hc

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ST_BUSY_BIT        0
`define ST_INIT_DONE_BIT   1
`define ST_INIT_CNT_LSB    2
`define ST_SERIAL_ACT_BIT  4
`define SLAVE_ADDR_RESET   7'h3a
`define ADDR_COUNTER_RESET 7'h00
`define MEM_DEPTH          7'h50
`define FSET_UPPER_NIBBLE  4'h3
`define INIT_FSET_COUNT    2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      5
`define EXEC_TIME_NS       40000

// ****************************************************************
// AXI responses
// ****************************************************************
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- src/sync_2ff.v
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit may change at any time relative to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
   parameter W = 1
) (
   input  wire         sys_clk,
   input  wire         srst,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   // First stage, read only by the second stage
   reg [W-1:0] meta;

   // ****************************************************************
   // Two stages; reset to idle-high is not needed, zero is fine
   // ****************************************************************
   always @(posedge sys_clk) begin
      if (srst) begin
         meta     <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule // sync_2ff
`default_nettype wire

//--- src/lcd_host_read_and_init.v
// Serial read path, parallel instruction port and init tracking of the LCD controller.
// Assumes bus pins arrive asynchronously and AXI4-Lite on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_read_defines.vh"

// Summary of operation
// - Read byte shifts staging out, MSB first
// - Master ack loads next memory location
// - No ack: interface and staging untouched
// - No ack: address counter and cursor hold
// - Busy indicator meaningless before three function sets
// - Low nibble of initial function sets ignored
// - Read address ack copies staging into interface
module lcd_host_read_and_init #(
   parameter BUSY_CYCLES = `EXEC_TIME_NS / `CLK_PERIOD_NS
) (
   input  wire        sys_clk,
   input  wire        srst,
   // Serial bus, open drain data
   input  wire        scl,
   input  wire        sda_in,
   output wire        sda_out,
   output reg         sda_oe,
   // Parallel instruction port
   input  wire        par_enable,
   input  wire        instruction_or_data_select,
   input  wire        par_read_not_write,
   input  wire [7:0]  par_db_in,
   output reg  [7:0]  par_db_out,
   output reg         par_db_oe,
   // AXI4-Lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // ****************************************************************
   // States, one-hot
   // ****************************************************************
   localparam [5:0] S_IDLE = 6'h01;   // Waiting for start
   localparam [5:0] S_ADDR = 6'h02;   // Receiving slave address
   localparam [5:0] S_AACK = 6'h04;   // Driving address acknowledge
   localparam [5:0] S_TX   = 6'h08;   // Shifting a read byte
   localparam [5:0] S_TACK = 6'h10;   // Master acknowledge slot
   localparam [5:0] S_WAIT = 6'h20;   // Ignoring until stop

   // ****************************************************************
   // Storage and state
   // ****************************************************************
   reg  [7:0]  display_text_memory [0:79];  // Character codes
   reg  [6:0]  addr_counter;                // Shared address counter
   reg  [7:0]  read_staging_register;       // Preloaded read data
   reg  [7:0]  shift_reg;                   // Serial interface register
   reg  [6:0]  slave_addr;                  // Own serial address
   reg  [5:0]  state;                       // Serial state
   reg  [3:0]  bit_cnt;                     // Bits seen in current byte
   reg         acked;                       // Master acked last byte
   reg  [1:0]  init_cnt;                    // Initial function sets seen
   reg  [13:0] busy_cnt;                    // Execution timer
   reg         scl_d;                       // Previous synced clock
   reg         sda_d;                       // Previous synced data
   reg         en_d;                        // Previous synced enable
   wire [12:0] pins_s;                      // Synchronised pins
   wire        scl_s;
   wire        sda_s;
   wire        en_s;
   wire        sel_s;
   wire        rw_s;
   wire [7:0]  db_s;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_cond;
   wire        stop_cond;
   wire        en_fall;
   wire [6:0]  ac_inc;                      // Counter plus one, wrapped
   wire        init_done;
   wire        busy_indicator;

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;

   // ****************************************************************
   // Pin synchronisation
   // ****************************************************************
   sync_2ff #(
      .W (13)
   ) u_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .async_in ({scl, sda_in, par_enable, instruction_or_data_select,
                  par_read_not_write, par_db_in}),
      .sync_out (pins_s)
   );

   assign scl_s = pins_s[12];
   assign sda_s = pins_s[11];
   assign en_s  = pins_s[10];
   assign sel_s = pins_s[9];
   assign rw_s  = pins_s[8];
   assign db_s  = pins_s[7:0];

   // Edge detectors look only at the synchronised stage
   always @(posedge sys_clk) begin
      if (srst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         en_d  <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         en_d  <= en_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
   assign en_fall    = en_d & ~en_s;
   assign ac_inc     = (addr_counter == `MEM_DEPTH - 7'h01) ? 7'h00 : addr_counter + 7'h01;
   assign init_done  = (init_cnt == `INIT_FSET_COUNT);
   // Reads as busy until the three function sets are in, so a poller waits
   assign busy_indicator = ~init_done | (busy_cnt != 14'h0000);

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   reg         aw_held;                     // Write address captured
   reg         w_held;                      // Write data captured
   reg  [3:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire        do_write;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write      = aw_held & w_held & ~s_axi_bvalid;

   // Address and data are taken in either order; response after both
   always @(posedge sys_clk) begin
      if (srst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Status and staging are read-only; unmapped gets an error
            s_axi_bresp  <= (aw_addr == `REG_ADDR_COUNTER || aw_addr == `REG_SLAVE_ADDR) ?
                            `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data; answer one cycle after the address is taken
   always @(posedge sys_clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         case (s_axi_araddr)
            `REG_ADDR_COUNTER : s_axi_rdata <= {25'h0, addr_counter};
            `REG_READ_STAGING : s_axi_rdata <= {24'h0, read_staging_register};
            `REG_STATUS       : s_axi_rdata <= {27'h0, ~state[0], init_cnt,
                                                init_done, busy_indicator};
            `REG_SLAVE_ADDR   : s_axi_rdata <= {25'h0, slave_addr};
            default : begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Serial slave state machine
   // ****************************************************************
   // Start or stop override any state; a repeated start begins anew
   always @(posedge sys_clk) begin
      if (srst) begin
         state     <= S_IDLE;
         bit_cnt   <= 4'h0;
         shift_reg <= 8'h00;
         sda_oe    <= 1'b0;
         acked     <= 1'b0;
      end else if (start_cond) begin
         state   <= S_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end else if (stop_cond) begin
         state  <= S_IDLE;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            S_IDLE : begin
               sda_oe <= 1'b0;
            end
            S_ADDR : begin
               // Sample address bits on the rising clock
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt   <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  if (shift_reg[7:1] == slave_addr && shift_reg[0]) begin
                     state     <= S_AACK;
                     sda_oe    <= 1'b1;
                     shift_reg <= read_staging_register;
                  end else begin
                     // Write transfers are not served by this block
                     state <= S_WAIT;
                  end
               end
            end
            S_AACK : begin
               // End of ack: present MSB of the staged byte
               if (scl_fall) begin
                  state   <= S_TX;
                  bit_cnt <= 4'h0;
                  sda_oe  <= ~shift_reg[7];
               end
            end
            S_TX : begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     // Release the line for the master's answer
                     state  <= S_TACK;
                     sda_oe <= 1'b0;
                     acked  <= 1'b0;
                  end else begin
                     bit_cnt   <= bit_cnt + 4'h1;
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sda_oe    <= ~shift_reg[6];
                  end
               end
            end
            S_TACK : begin
               if (scl_rise) begin
                  if (!sda_s) begin
                     acked     <= 1'b1;
                     shift_reg <= display_text_memory[ac_inc];
                  end
                  // No ack: shift register left as is
               end else if (scl_fall) begin
                  if (acked) begin
                     state   <= S_TX;
                     bit_cnt <= 4'h0;
                     sda_oe  <= ~shift_reg[7];
                  end else begin
                     state <= S_WAIT;
                  end
               end
            end
            S_WAIT : begin
               sda_oe <= 1'b0;
            end
            default : begin
               state  <= S_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Address counter, staging, memory and parallel port
   // ****************************************************************
   wire ack_seen = (state == S_TACK) && scl_rise && !sda_s && !start_cond && !stop_cond;
   wire par_wr   = en_fall && !rw_s;
   wire par_rd   = en_s && rw_s;
   wire axi_ac   = do_write && aw_addr == `REG_ADDR_COUNTER && w_strb[0];

   // Serial ack has priority over software moving the counter
   always @(posedge sys_clk) begin
      if (srst) begin
         addr_counter          <= `ADDR_COUNTER_RESET;
         read_staging_register <= 8'h00;
         slave_addr            <= `SLAVE_ADDR_RESET;
      end else begin
         if (ack_seen) begin
            addr_counter          <= ac_inc;
            read_staging_register <= display_text_memory[ac_inc];
         end else if (par_wr && sel_s) begin
            addr_counter          <= ac_inc;
            read_staging_register <= display_text_memory[ac_inc];
         end else if (axi_ac) begin
            addr_counter <= (w_data[6:0] < `MEM_DEPTH) ? w_data[6:0] : 7'h00;
            read_staging_register <= display_text_memory[
               (w_data[6:0] < `MEM_DEPTH) ? w_data[6:0] : 7'h00];
         end
         if (do_write && aw_addr == `REG_SLAVE_ADDR && w_strb[0])
            slave_addr <= w_data[6:0];
      end
   end

   // Memory is written only by data writes on the parallel port
   always @(posedge sys_clk) begin
      if (par_wr && sel_s)
         display_text_memory[addr_counter] <= db_s;
   end

   // Instruction tracking; the first three only need the upper nibble
   always @(posedge sys_clk) begin
      if (srst) begin
         init_cnt <= 2'h0;
         busy_cnt <= 14'h0000;
      end else begin
         if (busy_cnt != 14'h0000)
            busy_cnt <= busy_cnt - 14'h0001;
         if (par_wr && !sel_s) begin
            if (!init_done && db_s[7:4] == `FSET_UPPER_NIBBLE)
               init_cnt <= init_cnt + 2'h1;
            else if (init_done)
               busy_cnt <= BUSY_CYCLES[13:0];
         end
      end
   end

   // Parallel read: busy and counter, or staged data
   always @(posedge sys_clk) begin
      if (srst) begin
         par_db_out <= 8'h00;
         par_db_oe  <= 1'b0;
      end else begin
         par_db_oe  <= par_rd;
         par_db_out <= sel_s ? read_staging_register : {busy_indicator, addr_counter};
      end
   end

endmodule // lcd_host_read_and_init
`default_nettype wire

//--- tb/lcd_read_chk.sv
// Port checker for the LCD read and init block.
// Assumes binding onto lcd_host_read_and_init, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lcd_read_chk (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        scl,
   input wire logic        sda_oe,
   input wire logic        par_enable,
   input wire logic        par_read_not_write,
   input wire logic        par_db_oe,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ************************************************
   // Properties
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
   // Reset itself is the cause here, so it must not disable the check
   property p_rst; disable iff (1'b0) srst |=> !sda_oe && !par_db_oe && !s_axi_bvalid && !s_axi_rvalid; endproperty
   property p_bans; s_wtake |-> ##2 s_axi_bvalid; endproperty
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   property p_rans; s_rtake |=> s_axi_rvalid; endproperty
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_ardly; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   // Parallel bus is only driven for a read with the enable up
   property p_poe; par_db_oe |-> par_read_not_write; endproperty
   property p_poff; !par_enable [*6] |-> !par_db_oe; endproperty
   // Data line only moves while the serial clock is low
   property p_sstab; scl [*5] |-> $stable(sda_oe); endproperty
   property p_srise; $rose(sda_oe) |-> !scl; endproperty
   a_rst:   assert property (p_rst) else $error("outputs active after reset");
   a_bans:  assert property (p_bans) else $error("no write response");
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   a_rans:  assert property (p_rans) else $error("no read response");
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   a_ardly: assert property (p_ardly) else $error("read response not retired");
   a_poe:   assert property (p_poe) else $error("parallel bus driven on write");
   a_poff:  assert property (p_poff) else $error("parallel bus driven while idle");
   a_sstab: assert property (p_sstab) else $error("data line moved with clock high");
   a_srise: assert property (p_srise) else $error("ack raised with clock high");
endmodule // lcd_read_chk
bind lcd_host_read_and_init lcd_read_chk u_lcd_read_chk (.sys_clk(sys_clk), .srst(srst),
   .scl(scl), .sda_oe(sda_oe), .par_enable(par_enable), .par_read_not_write(par_read_not_write),
   .par_db_oe(par_db_oe), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- tb/serial_host_model.sv
// Two-wire bus master model standing in for the host controller.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   output logic      scl,
   output logic      sda_rel,
   input  wire logic sda
);
   localparam int Q = 16; // Quarter of the 64 ns bit time
   // Clock parks high outside frames, line released
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic start();
      sda_rel = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda_rel = 1'b0;
      #Q scl = 1'b1;
      #Q sda_rel = 1'b1;
      #Q;
   endtask
   // Data changes mid low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic s);
      sda_rel = b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, ack); // Released for the device's ack
   endtask
   // nack high leaves the line released in the ack slot
   task automatic recv(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(nack, s);
   endtask
endmodule // serial_host_model
`default_nettype wire

//--- tb/test_lcd_host_read_and_init.sv
// Self-checking bench: AXI4-Lite, parallel init and serial reads.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_read_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_lcd_host_read_and_init;
   logic        sys_clk, srst, scl, sda_rel, sda_out, sda_oe, par_enable, sel, rw, par_db_oe;
   logic [7:0]  db, par_db_out, lf, d, mem [0:2];
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        watch, ack;
   wire         sda_in = sda_rel & ~(sda_oe & ~sda_out); // Pull-up resolves the line
   logic [33:0] expq [$]; // Expected {resp, data} notes
   logic [7:0]  ser;
   event        got;
   int          n_errors = 0, n_checks = 0, cyc = 0;
   lcd_host_read_and_init #(.BUSY_CYCLES(20)) u_lcd_host_read_and_init (
      .sys_clk(sys_clk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .par_enable(par_enable), .instruction_or_data_select(sel),
      .par_read_not_write(rw), .par_db_in(db), .par_db_out(par_db_out), .par_db_oe(par_db_oe),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   serial_host_model u_serial_host_model (.scl(scl), .sda_rel(sda_rel), .sda(sda_in));
   // ************************************************
   // Clock, timeout, result watcher
   // ************************************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Whole run needs about 1300 cycles; cut off well beyond
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         stop_test();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic take(input string nm, input logic [33:0] g);
      logic [33:0] e;
      e = (expq.size() > 0) ? expq.pop_front() : 34'hx;
      `CHK(nm, e, g)
   endtask
   // Bus answers are compared at their handshake edge
   always @(posedge sys_clk) begin
      if (watch && s_axi_rvalid && s_axi_rready) take("axi read", {s_axi_rresp, s_axi_rdata});
      if (watch && s_axi_bvalid && s_axi_bready) take("axi write", {s_axi_bresp, 32'h0});
   end
   always @(got) take("pin byte", {26'h0, ser});
   // ************************************************
   // Drivers
   // ************************************************
   task automatic axw(input logic [3:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] x);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      x = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Checked accesses note the expectation first
   task automatic rchk(input logic [3:0] a, input logic [33:0] e);
      expq.push_back(e);
      watch <= 1'b1;
      axr(a, v);
      watch <= 1'b0;
   endtask
   task automatic wchk(input logic [3:0] a, input logic [31:0] x, input logic [1:0] r);
      expq.push_back({r, 32'h0});
      watch <= 1'b1;
      axw(a, x);
      watch <= 1'b0;
   endtask
   task automatic nser(input logic [7:0] e, input logic [7:0] g);
      expq.push_back({26'h0, e});
      ser = g;
      -> got;
   endtask
   task automatic idle();
      do axr(4'h8, v); while (v[0] !== 1'b0);
   endtask
   // Enable held for 6 cycles so the synchroniser sees it
   task automatic pin(input logic s, input logic r, input logic [7:0] x);
      @(posedge sys_clk);
      sel <= s;
      rw <= r;
      db <= x;
      par_enable <= 1'b1;
      repeat (6) @(posedge sys_clk);
      if (r) nser(x, par_db_oe ? par_db_out : ~x);
      par_enable <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      {srst, watch, lf} = {2'b10, 8'h12};
      {par_enable, sel, rw, db, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rchk(4'hc, {`RESP_OKAY, 25'h0, `SLAVE_ADDR_RESET});
      rchk(4'h8, {`RESP_OKAY, 32'h1});
      wchk(4'h4, 32'h55, `RESP_SLVERR);
      rchk(4'h2, {`RESP_SLVERR, 32'h0});
      // Init waits shortened: the device does not time them
      for (int i = 0; i < 3; i++) begin
         lf = lfsr(lf);
         repeat (40) @(posedge sys_clk);
         pin(1'b0, 1'b0, {`FSET_UPPER_NIBBLE, lf[3:0]});
      end
      repeat (30) @(posedge sys_clk);
      rchk(4'h8, {`RESP_OKAY, 32'he});
      for (int k = 0; k < 4; k++) begin
         pin(1'b0, 1'b0, (k == 0) ? 8'h38 : (k == 1) ? 8'h08 : (k == 2) ? 8'h01 : 8'h06);
         rchk(4'h8, {`RESP_OKAY, 32'hf});
         idle();
      end
      wchk(4'h0, 32'h0, `RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         lf = lfsr(lf);
         mem[k] = lf;
         pin(1'b1, 1'b0, lf);
         idle();
      end
      wchk(4'h0, 32'h0, `RESP_OKAY);
      u_serial_host_model.start();
      u_serial_host_model.send({`SLAVE_ADDR_RESET, 1'b1}, ack);
      nser(8'h0, {7'h0, ack});
      for (int k = 0; k < 3; k++) begin
         u_serial_host_model.recv(k == 2, d);
         nser(mem[k], d);
      end
      u_serial_host_model.stop();
      rchk(4'h0, {`RESP_OKAY, 32'h2});
      rchk(4'h4, {`RESP_OKAY, 24'h0, mem[2]});
      u_serial_host_model.start();
      u_serial_host_model.send({`SLAVE_ADDR_RESET, 1'b1}, ack);
      u_serial_host_model.recv(1'b1, d);
      nser(mem[2], d);
      u_serial_host_model.stop();
      u_serial_host_model.start();
      u_serial_host_model.send({`SLAVE_ADDR_RESET, 1'b0}, ack);
      nser(8'h1, {7'h0, ack});
      u_serial_host_model.stop();
      pin(1'b0, 1'b1, 8'h02);
      stop_test();
   end
endmodule // test_lcd_host_read_and_init
`default_nettype wire
